/* File: rtl/dram_core_end.sv */
// dram core end: banks, prefetch word store, refresh and self refresh
`default_nettype none
module dram_core_end
    import dram_link_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst,
    dram_link_if.dev           link,
    output logic               illegalCmd,
    output logic               selfRefreshActive,
    output logic [REFCNT_W-1:0] refreshCount,
    output logic [NUM_BANKS-1:0] openBanks
);
    logic [CORE_W-1:0]     mem_r [NUM_ENTRIES];
    logic [CORE_W-1:0]     wrWord_r;
    logic [CORE_W-1:0]     rdWord_r;
    logic [PHASE_W-1:0]    wrPhase_r;
    logic [PHASE_W-1:0]    rdPhase_r;
    logic [ENTRY_W-1:0]    wrIdx_r;
    logic                  ckePrev_r;
    logic                  sr_r;
    logic                  illegal_r;
    logic [REFCNT_W-1:0]   refCnt_r;
    logic [NUM_BANKS-1:0]  open_r;
    logic [BEAT_PAIR_W-1:0] devDq_r;
    logic                  devDqOe_r;
    logic [BG_W-1:0]       bgSel;
    logic [BANK_W-1:0]     bankIdx;
    logic [ENTRY_W-1:0]    entryIdx;
    logic                  cmdSel;
    logic                  isAct;
    logic                  isRef;
    logic                  isPre;
    logic                  isWr;
    logic                  isRd;
    logic                  isBad;
    logic                  bankIsOpen;
    logic                  commit;

    // x16 has two bank groups, upper group bit ignored
    assign bgSel      = (NUM_BG == 2) ? {1'b0, link.bg[0]} : link.bg;
    assign bankIdx    = {bgSel, link.ba};
    assign entryIdx   = {bankIdx, link.addr[COL_LSB +: COL_W]};
    assign cmdSel     = !link.csN && !sr_r;
    assign isAct      = cmdSel && !link.actN;
    assign isRef      = cmdSel && link.actN && link.cmd == CMD_REF;
    assign isPre      = cmdSel && link.actN && link.cmd == CMD_PRE;
    assign isWr       = cmdSel && link.actN && link.cmd == CMD_WR && wrPhase_r == '0;
    assign isRd       = cmdSel && link.actN && link.cmd == CMD_RD && rdPhase_r == '0;
    assign bankIsOpen = open_r[bankIdx];
    assign commit     = wrPhase_r == PHASE_W'(BEAT_CYC);
    // NOP and reserved codes are outside what this model supports
    assign isBad = (cmdSel && link.actN && (link.cmd == CMD_NOP || link.cmd == CMD_RFU))
                 || (isAct && bankIsOpen)
                 || ((isWr || isRd) && !bankIsOpen)
                 || (sr_r && !link.csN && !link.cke);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ckePrev_r <= 1'b1;
            sr_r      <= 1'b0;
        end else begin
            ckePrev_r <= link.cke;
            if (isRef && !link.cke && ckePrev_r) begin
                sr_r <= 1'b1;
            end else if (sr_r && link.cke) begin
                sr_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            refCnt_r  <= '0;
            illegal_r <= 1'b0;
        end else begin
            illegal_r <= isBad;
            if (isRef) begin
                refCnt_r <= refCnt_r + REFCNT_W'(1);
            end
        end
    end

    // auto precharge on a10 closes the bank once the burst is issued
    always_ff @(posedge core_clk) begin
        if (rst) begin
            open_r <= '0;
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (isPre && (link.addr[AP_BIT] || bankIdx == BANK_W'(b))) begin
                    open_r[b] <= 1'b0;
                end else if ((isWr || isRd) && link.addr[AP_BIT] && bankIdx == BANK_W'(b)) begin
                    open_r[b] <= 1'b0;
                end else if (isAct && bankIdx == BANK_W'(b)) begin
                    open_r[b] <= 1'b1;
                end
            end
        end
    end

    // write: gather two beats per clock into one core word
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPhase_r <= '0;
            wrIdx_r   <= '0;
            wrWord_r  <= '0;
        end else if (isWr && bankIsOpen) begin
            wrPhase_r <= PHASE_W'(WRITE_LAT);
            wrIdx_r   <= entryIdx;
        end else if (wrPhase_r != '0) begin
            wrWord_r[(wrPhase_r - PHASE_W'(1)) * BEAT_PAIR_W +: BEAT_PAIR_W] <= link.dq;
            wrPhase_r <= commit ? '0 : wrPhase_r + PHASE_W'(1);
        end
    end

    // one flop per entry; the whole 8n word lands in a single cycle
    for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_entry
        always_ff @(posedge core_clk) begin
            if (commit && wrIdx_r == ENTRY_W'(e)) begin
                mem_r[e] <= {link.dq, wrWord_r[CORE_W-BEAT_PAIR_W-1:0]};
            end
        end
    end

    // read: fetch the full word, then two beats per clock on the pins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdPhase_r <= '0;
            rdWord_r  <= '0;
            devDq_r   <= '0;
            devDqOe_r <= 1'b0;
        end else if (isRd && bankIsOpen) begin
            rdPhase_r <= PHASE_W'(READ_LAT - 1);
            rdWord_r  <= mem_r[entryIdx];
        end else if (rdPhase_r != '0) begin
            if (rdPhase_r <= PHASE_W'(BEAT_CYC)) begin
                devDq_r   <= rdWord_r[(rdPhase_r - PHASE_W'(1)) * BEAT_PAIR_W +: BEAT_PAIR_W];
                devDqOe_r <= 1'b1;
                rdPhase_r <= rdPhase_r + PHASE_W'(1);
            end else begin
                devDqOe_r <= 1'b0;
                rdPhase_r <= '0;
            end
        end
    end

    // timing assumed with dll enabled; no dll-off latency path exists
    assign link.devDq        = devDq_r;
    assign link.devDqOe      = devDqOe_r;
    assign illegalCmd        = illegal_r;
    assign selfRefreshActive = sr_r;
    assign refreshCount      = refCnt_r;
    assign openBanks         = open_r;
endmodule
`default_nettype wire

/* File: rtl/dram_ctrl_end.sv */
// memory controller end: access sequencing, refresh schedule, keep-alive
`default_nettype none
// Operation
// - x16 eight banks, x4/x8 sixteen banks
// - four banks per group, group plus bank
// - burst moves one 8n word, four clocks
// - idle cycles send deselect, never nop
// - normal range: refresh every 7.8125 us
// - hot range: refresh every 3.90625 us; code runs a normal interval first after reset or self refresh exit
// - hot range also enables high-temp self refresh
// - toggle select within 8192 refresh intervals
// - behaviour assumes dll enabled
// - only defined commands are ever issued
module dram_ctrl_end
    import dram_link_pkg::*;
#(
    parameter int KEEPALIVE_CYC = KEEPALIVE_CYC_DEF
)
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    dram_link_if.host              link,
    input  wire logic              hotRange,
    input  wire logic              srReq,
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire logic [BG_W-1:0]   reqBg,
    input  wire logic [BA_W-1:0]   reqBa,
    input  wire logic [ADDR_W-1:0] reqRow,
    input  wire logic [COL_W-1:0]  reqCol,
    input  wire logic [CORE_W-1:0] reqWdata,
    output logic                   reqReady,
    output logic                   rdValid,
    output logic [CORE_W-1:0]      rdData,
    output logic                   hiTempSrEnable,
    output logic                   refreshIssued,
    output logic                   selfRefreshOn
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ACTW = 6'h02,
        ST_XFER = 6'h04,
        ST_PREW = 6'h08,
        ST_REFW = 6'h10,
        ST_SELF = 6'h20
    } state_t;

    state_t                 state_r;
    logic                   reqReady_r;
    logic                   isWrite_r;
    logic [CORE_W-1:0]      wdata_r;
    logic [CORE_W-1:0]      rdData_r;
    logic                   rdValid_r;
    logic [WAIT_W-1:0]      wait_r;
    logic [PHASE_W-1:0]     phase_r;
    logic                   cke_r;
    logic                   csN_r;
    logic                   actN_r;
    cmd_code_t              cmd_r;
    logic [BG_W-1:0]        bg_r;
    logic [BA_W-1:0]        ba_r;
    logic [ADDR_W-1:0]      addr_r;
    logic [BEAT_PAIR_W-1:0] dq_r;
    logic                   dqOe_r;
    logic [REFI_W-1:0]      refi_r;
    logic                   refDue_r;
    logic [KA_W-1:0]        ka_r;
    logic                   refIssued_r;
    logic                   hiTemp_r;
    logic                   take;
    logic                   refStart;
    logic                   refExpire;
    logic                   kaExpire;
    logic [COL_W-1:0]       colHold_r;

    assign take      = state_r == ST_IDLE && reqReady_r && reqValid;
    assign refStart  = state_r == ST_IDLE && !take && refDue_r;
    assign refExpire = refi_r == '0;
    assign kaExpire  = ka_r >= KA_W'(KEEPALIVE_CYC - 1);

    // interval counter reloads from the range in force at expiry
    always_ff @(posedge core_clk) begin
        if (rst || state_r == ST_SELF) begin
            refi_r <= REFI_W'(REFI_NORM_CYC - 1);
        end else if (refExpire) begin
            refi_r <= hotRange ? REFI_W'(REFI_HOT_CYC - 1)
                               : REFI_W'(REFI_NORM_CYC - 1);
        end else begin
            refi_r <= refi_r - REFI_W'(1);
        end
    end

    // a new expiry in the issue cycle keeps the flag set
    always_ff @(posedge core_clk) begin
        if (rst || state_r == ST_SELF) begin
            refDue_r <= 1'b0;
        end else if (refExpire || kaExpire) begin
            refDue_r <= 1'b1;
        end else if (refStart) begin
            refDue_r <= 1'b0;
        end
    end

    // self refresh lifts the keep-alive need, so the count rests there
    always_ff @(posedge core_clk) begin
        if (rst || state_r == ST_SELF || !csN_r) begin
            ka_r <= '0;
        end else if (!kaExpire) begin
            ka_r <= ka_r + KA_W'(1);
        end
    end

    // hot range must also flag the high-temperature self refresh option
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hiTemp_r <= 1'b0;
        end else begin
            hiTemp_r <= hotRange;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdValid_r <= 1'b0;
            rdData_r  <= '0;
        end else begin
            rdValid_r <= state_r == ST_XFER && !isWrite_r
                         && phase_r == PHASE_W'(READ_LAT + BEAT_CYC);
            // phase is one ahead of the link cycle count from the read command
            if (state_r == ST_XFER && !isWrite_r && phase_r > PHASE_W'(READ_LAT)) begin
                rdData_r[(phase_r - PHASE_W'(READ_LAT + 1)) * BEAT_PAIR_W +: BEAT_PAIR_W]
                    <= link.dq;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r     <= ST_IDLE;
            reqReady_r  <= 1'b0;
            isWrite_r   <= 1'b0;
            wdata_r     <= '0;
            wait_r      <= '0;
            phase_r     <= '0;
            cke_r       <= 1'b1;
            csN_r       <= 1'b1;
            actN_r      <= 1'b1;
            cmd_r       <= CMD_NOP;
            bg_r        <= '0;
            ba_r        <= '0;
            addr_r      <= '0;
            dq_r        <= '0;
            dqOe_r      <= 1'b0;
            refIssued_r <= 1'b0;
        end else begin
            // default every cycle is deselect
            csN_r       <= 1'b1;
            actN_r      <= 1'b1;
            cmd_r       <= CMD_NOP;
            refIssued_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        reqReady_r <= 1'b0;
                        isWrite_r  <= reqWrite;
                        wdata_r    <= reqWdata;
                        csN_r      <= 1'b0;
                        actN_r     <= 1'b0;
                        bg_r       <= reqBg;
                        ba_r       <= reqBa;
                        addr_r     <= reqRow;
                        wait_r     <= WAIT_W'(TRCD_CYC - 1);
                        state_r    <= ST_ACTW;
                    end else if (refDue_r) begin
                        reqReady_r  <= 1'b0;
                        csN_r       <= 1'b0;
                        cmd_r       <= CMD_REF;
                        refIssued_r <= 1'b1;
                        wait_r      <= WAIT_W'(TRFC_CYC - 1);
                        state_r     <= ST_REFW;
                    end else if (srReq) begin
                        reqReady_r  <= 1'b0;
                        csN_r       <= 1'b0;
                        cke_r       <= 1'b0;
                        cmd_r       <= CMD_REF;
                        refIssued_r <= 1'b1;
                        state_r     <= ST_SELF;
                    end else begin
                        reqReady_r <= 1'b1;
                    end
                end
                ST_ACTW: begin
                    if (wait_r != '0) begin
                        wait_r <= wait_r - WAIT_W'(1);
                    end else begin
                        // auto precharge keeps every bank closed when idle
                        csN_r   <= 1'b0;
                        cmd_r   <= isWrite_r ? CMD_WR : CMD_RD;
                        addr_r  <= ADDR_W'({colHold_r, 3'h0}) | (ADDR_W'(1) << AP_BIT);
                        phase_r <= PHASE_W'(1);
                        state_r <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    phase_r <= phase_r + PHASE_W'(1);
                    // pairs trail the write command by one cycle, where the core samples
                    if (isWrite_r) begin
                        if (phase_r <= PHASE_W'(BEAT_CYC)) begin
                            dq_r <= wdata_r[(phase_r - PHASE_W'(1)) * BEAT_PAIR_W +: BEAT_PAIR_W];
                            dqOe_r <= 1'b1;
                        end else begin
                            dqOe_r  <= 1'b0;
                            wait_r  <= WAIT_W'(TRP_CYC - 1);
                            state_r <= ST_PREW;
                        end
                    end else if (phase_r == PHASE_W'(READ_LAT + BEAT_CYC)) begin
                        wait_r  <= WAIT_W'(TRP_CYC - 1);
                        state_r <= ST_PREW;
                    end
                end
                ST_PREW, ST_REFW: begin
                    if (wait_r != '0) begin
                        wait_r <= wait_r - WAIT_W'(1);
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_SELF: begin
                    if (!srReq) begin
                        cke_r   <= 1'b1;
                        wait_r  <= WAIT_W'(TXS_CYC - 1);
                        state_r <= ST_REFW;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // column held from acceptance; the live request port may have moved on
    always_ff @(posedge core_clk) begin
        if (rst) begin
            colHold_r <= '0;
        end else if (take) begin
            colHold_r <= reqCol;
        end
    end

    // timing assumes dll enabled; no dll-off latencies are scheduled
    assign link.cke      = cke_r;
    assign link.csN      = csN_r;
    assign link.actN     = actN_r;
    assign link.cmd      = cmd_r;
    assign link.bg       = bg_r;
    assign link.ba       = ba_r;
    assign link.addr     = addr_r;
    assign link.hostDq   = dq_r;
    assign link.hostDqOe = dqOe_r;
    assign reqReady      = reqReady_r;
    assign rdValid       = rdValid_r;
    assign rdData        = rdData_r;
    assign hiTempSrEnable = hiTemp_r;
    assign refreshIssued = refIssued_r;
    assign selfRefreshOn = state_r[5]; // one-hot self refresh bit, straight from the flop
endmodule
`default_nettype wire

/* File: rtl/dram_link_if.sv */
// link between memory controller end and dram core end
`default_nettype none
interface dram_link_if;
    import dram_link_pkg::*;
    logic                   cke;
    logic                   csN;
    logic                   actN;
    cmd_code_t              cmd;
    logic [BG_W-1:0]        bg;
    logic [BA_W-1:0]        ba;
    logic [ADDR_W-1:0]      addr;
    logic [BEAT_PAIR_W-1:0] hostDq;
    logic                   hostDqOe;
    logic [BEAT_PAIR_W-1:0] devDq;
    logic                   devDqOe;
    logic [BEAT_PAIR_W-1:0] dq;
    // rising beat in low half, falling beat in high half
    assign dq = hostDqOe ? hostDq : (devDqOe ? devDq : '0);
    modport host (output cke, csN, actN, cmd, bg, ba, addr, hostDq, hostDqOe,
                  input devDqOe, dq);
    modport dev  (input cke, csN, actN, cmd, bg, ba, addr, hostDqOe, dq,
                  output devDq, devDqOe);
endinterface
`default_nettype wire

/* File: rtl/dram_link_pkg.sv */
// shared constants and types for the dram command/data link
`default_nettype none
package dram_link_pkg;
    localparam int DQ_W          = 8;
    localparam int BEAT_PAIR_W   = 2 * DQ_W;
    localparam int BURST_BEATS   = 8;
    localparam int CORE_W        = DQ_W * BURST_BEATS;
    localparam int BEAT_CYC      = 4;
    localparam int NUM_BG        = (DQ_W == 16) ? 2 : 4;
    localparam int BANKS_PER_BG  = 4;
    localparam int NUM_BANKS     = NUM_BG * BANKS_PER_BG;
    localparam int BG_W          = 2;
    localparam int BA_W          = 2;
    localparam int BANK_W        = BG_W + BA_W;
    localparam int ADDR_W        = 11;
    localparam int COL_LSB       = 3;
    localparam int COL_W         = 2;
    localparam int AP_BIT        = 10;
    localparam int ENTRY_W       = BANK_W + COL_W;
    localparam int NUM_ENTRIES   = NUM_BANKS * (1 << COL_W);
    localparam int PHASE_W       = 3;
    localparam int WAIT_W        = 4;
    localparam int WRITE_LAT     = 1;
    localparam int READ_LAT      = 2;
    localparam int TRCD_CYC      = 2;
    localparam int TRP_CYC       = 2;
    localparam int TRFC_CYC      = 8;
    localparam int TXS_CYC       = 8;
    localparam int CLK_PERIOD_PS = 20000;
    localparam int TREFI_NORM_PS = 7812500;
    localparam int TREFI_HOT_PS  = 3906250;
    // longest times: round down
    localparam int REFI_NORM_CYC = TREFI_NORM_PS / CLK_PERIOD_PS;
    localparam int REFI_HOT_CYC  = TREFI_HOT_PS / CLK_PERIOD_PS;
    localparam int REFI_W        = 9;
    localparam int KEEPALIVE_REFI = 8192;
    localparam int KEEPALIVE_CYC_DEF = KEEPALIVE_REFI * REFI_NORM_CYC;
    localparam int KA_W          = 22;
    localparam int REFCNT_W      = 16;
    // command code on {ras_n, cas_n, we_n} when act_n is high
    typedef logic [2:0] cmd_code_t;
    localparam cmd_code_t CMD_MRS = 3'h0;
    localparam cmd_code_t CMD_REF = 3'h1;
    localparam cmd_code_t CMD_PRE = 3'h2;
    localparam cmd_code_t CMD_RFU = 3'h3;
    localparam cmd_code_t CMD_WR  = 3'h4;
    localparam cmd_code_t CMD_RD  = 3'h5;
    localparam cmd_code_t CMD_ZQ  = 3'h6;
    localparam cmd_code_t CMD_NOP = 3'h7;
endpackage
`default_nettype wire

/* File: test/dram_link_chk.sv */
// link protocol checker between controller end and dram core end
`default_nettype none
module dram_link_chk
    import dram_link_pkg::*;
#(
    parameter int KEEPALIVE_CYC = 600
)
(
    input wire logic            core_clk,
    input wire logic            rst,
    input wire logic            cke,
    input wire logic            csN,
    input wire logic            actN,
    input wire cmd_code_t       cmd,
    input wire logic [BG_W-1:0] bg,
    input wire logic [BA_W-1:0] ba,
    input wire logic            hostDqOe,
    input wire logic            devDqOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // slack covers a refresh deferred behind the one user access in flight
    localparam int REF_LIMIT = REFI_NORM_CYC + 160;
    logic        isRef;
    logic [9:0]  refGap;
    logic [KA_W-1:0] csGap;
    assign isRef = !csN && actN && (cmd == CMD_REF);
    always_ff @(posedge core_clk) begin
        if (rst || isRef || !cke) refGap <= '0;
        else refGap <= refGap + 10'h001;
    end
    always_ff @(posedge core_clk) begin
        if (rst || !csN || !cke) csGap <= '0;
        else csGap <= csGap + KA_W'(1);
    end
    a_no_nop_cmd: assert property (!csN && actN |-> cmd != CMD_NOP)
        else $error("nop sent on link");
    a_no_rfu_cmd: assert property (!csN && actN |-> cmd != CMD_RFU)
        else $error("reserved command sent");
    a_write_four_pairs: assert property (!csN && actN && cmd == CMD_WR
        |-> ##[0:1] hostDqOe [*4] ##1 !hostDqOe) else $error("write burst length wrong");
    a_read_four_pairs: assert property (!csN && actN && cmd == CMD_RD
        |-> ##2 devDqOe [*4] ##1 !devDqOe) else $error("read burst length wrong");
    a_act_then_access: assert property (!csN && !actN |-> ##2 (!csN && actN
        && (cmd == CMD_RD || cmd == CMD_WR) && bg == $past(bg, 2) && ba == $past(ba, 2)))
        else $error("access does not follow activate");
    a_x16_bank_range: assert property (!csN && DQ_W == 16 |-> !bg[1])
        else $error("bank group out of range");
    a_refresh_due: assert property (refGap < REF_LIMIT)
        else $error("refresh overdue");
    a_keepalive_cs: assert property (csGap < KEEPALIVE_CYC)
        else $error("select not toggled in time");
    a_cke_drop_ref: assert property ($fell(cke) |-> isRef)
        else $error("clock enable dropped without self refresh");
    a_ref_recover: assert property (isRef && cke |=> csN [*7])
        else $error("command inside refresh recovery");
    a_dq_one_driver: assert property (!(hostDqOe && devDqOe))
        else $error("both ends drive data");
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench: controller end and dram core end back to back
`default_nettype none
module tb;
    import dram_link_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic                core_clk, rst, hotRange, srReq, reqValid, reqWrite;
    logic [BG_W-1:0]     reqBg;
    logic [BA_W-1:0]     reqBa;
    logic [ADDR_W-1:0]   reqRow;
    logic [COL_W-1:0]    reqCol;
    logic [CORE_W-1:0]   reqWdata, rdData;
    logic                reqReady, rdValid, hiTempSrEnable, refreshIssued, selfRefreshOn;
    logic                illegalCmd, selfRefreshActive;
    logic [REFCNT_W-1:0] refreshCount;
    logic [NUM_BANKS-1:0] openBanks;
    int                  bad_count, num_checks;
    logic                sawIllegal;
    // illegal command is a one-cycle pulse, so keep it sticky for the checks
    always_ff @(posedge core_clk) begin
        sawIllegal <= !rst && (sawIllegal || illegalCmd === 1'b1);
    end
    dram_link_if link();
    dram_ctrl_end #(.KEEPALIVE_CYC(600)) dram_ctrl_end_inst (.core_clk(core_clk), .rst(rst),
        .link(link), .hotRange(hotRange), .srReq(srReq), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqBg(reqBg), .reqBa(reqBa), .reqRow(reqRow), .reqCol(reqCol),
        .reqWdata(reqWdata), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
        .hiTempSrEnable(hiTempSrEnable), .refreshIssued(refreshIssued),
        .selfRefreshOn(selfRefreshOn));
    dram_core_end dram_core_end_inst (.core_clk(core_clk), .rst(rst), .link(link),
        .illegalCmd(illegalCmd), .selfRefreshActive(selfRefreshActive),
        .refreshCount(refreshCount), .openBanks(openBanks));
    dram_link_chk #(.KEEPALIVE_CYC(600)) dram_link_chk_inst (.core_clk(core_clk), .rst(rst),
        .cke(link.cke), .csN(link.csN), .actN(link.actN), .cmd(link.cmd), .bg(link.bg),
        .ba(link.ba), .hostDqOe(link.hostDqOe), .devDqOe(link.devDqOe));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one user access; a read waits for its word and compares it
    task automatic access(input logic wr, input logic [BANK_W-1:0] bank,
                          input logic [COL_W-1:0] col, input logic [CORE_W-1:0] data);
        int n;
        for (n = 0; n < 600 && reqReady !== 1'b1; n++) @(negedge core_clk);
        reqValid = 1'b1;
        reqWrite = wr;
        {reqBg, reqBa} = bank;
        reqCol = col;
        reqRow = {7'h00, bank};
        reqWdata = wr ? data : ~data;
        @(negedge core_clk);
        reqValid = 1'b0;
        if (!wr) begin
            for (n = 0; n < 30 && rdValid !== 1'b1; n++) @(negedge core_clk);
            check("read word", rdData, data);
        end
    endtask
    task automatic wait_ref(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (n < 1000 && refreshIssued !== 1'b1);
    endtask
    task automatic t_access();
        int i;
        for (i = 0; i < 4; i++) access(1'b1, 4'(i * 5), 2'(i), 64'h0123_4567_89AB_CDEF * (i + 1));
        for (i = 0; i < 4; i++) begin
            access(1'b0, 4'(i * 5), 2'(i), 64'h0123_4567_89AB_CDEF * (i + 1));
        end
        access(1'b1, 4'hF, 2'h3, 64'h5A5A_0F0F_F0F0_A5A5);
        access(1'b0, 4'hF, 2'h3, 64'h5A5A_0F0F_F0F0_A5A5);
        repeat (12) @(negedge core_clk);
        check("banks closed", 64'(openBanks), 64'h0);
        check("no illegal command", 64'(sawIllegal), 64'h0);
    endtask
    task automatic t_refresh(input logic hot, input int terminal);
        int gap;
        logic [REFCNT_W-1:0] cnt;
        hotRange = hot;
        wait_ref(gap);
        wait_ref(gap);
        cnt = refreshCount;
        wait_ref(gap);
        // one cycle of slack for the idle hand-off into the refresh
        check("refresh gap", 64'(gap >= terminal && gap <= terminal + 1), 64'h1);
        check("refresh count", 64'(refreshCount - cnt), 64'h1);
        check("high temp self refresh", 64'(hiTempSrEnable), 64'(hot));
    endtask
    task automatic t_selfref();
        int n;
        logic [REFCNT_W-1:0] cnt;
        srReq = 1'b1;
        for (n = 0; n < 1000 && selfRefreshOn !== 1'b1; n++) @(negedge core_clk);
        @(negedge core_clk);
        check("cke parked low", 64'(link.cke), 64'h0);
        check("device in self refresh", 64'(selfRefreshActive), 64'h1);
        cnt = refreshCount;
        repeat (900) @(negedge core_clk);
        check("no refresh while parked", 64'(refreshCount), 64'(cnt));
        srReq = 1'b0;
        for (n = 0; n < 50 && selfRefreshOn !== 1'b0; n++) @(negedge core_clk);
        check("cke restored", 64'(link.cke), 64'h1);
        access(1'b0, 4'hF, 2'h3, 64'h5A5A_0F0F_F0F0_A5A5);
        check("no illegal after exit", 64'(sawIllegal), 64'h0);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
    initial begin
        {hotRange, srReq, reqValid, reqWrite, reqBg, reqBa} = '0;
        rst = 1'b1;
        {reqRow, reqCol, reqWdata} = '0;
        bad_count = 0;
        num_checks = 0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        t_access();
        t_refresh(1'b0, REFI_NORM_CYC);
        t_refresh(1'b1, REFI_HOT_CYC);
        hotRange = 1'b0;
        t_selfref();
        summarize();
    end
endmodule
`default_nettype wire
